/* src/pth_byte_mem.sv */
// file: four-byte register memory holding the threshold bytes, registered read port
`timescale 1ns/100ps
module pth_byte_mem (
  input  wire logic                       clk,      // system clock
  input  wire logic                       reset_n,  // async reset, active low
  input  wire logic                       wr_en,    // write strobe
  input  wire logic [pth_pkg::IDX_W-1:0]  wr_idx,   // write index
  input  wire logic [7:0]                 wr_data,  // write byte
  input  wire logic [pth_pkg::IDX_W-1:0]  rd_idx,   // read index
  output logic      [7:0]                 rd_data,  // registered read byte
  output logic      [8*pth_pkg::NUM_BYTES-1:0] all_bytes // live contents
);
  logic [7:0] mem_r [pth_pkg::NUM_BYTES];

  // byte storage, each byte written on its own
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < pth_pkg::NUM_BYTES; i++) mem_r[i] <= pth_pkg::RESET_BYTE;
    end else if (wr_en) begin
      mem_r[wr_idx] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= pth_pkg::RESET_BYTE;
    end else begin
      rd_data <= mem_r[rd_idx];
    end
  end

  // flat view for the comparators
  always_comb begin
    for (int i = 0; i < pth_pkg::NUM_BYTES; i++) all_bytes[8*i +: 8] = mem_r[i];
  end
endmodule

/* src/pth_pkg.sv */
// package: register map, reset values and record types of the proximity threshold bank
package pth_pkg;
  localparam logic [7:0] ADDR_CHAN2_LOW  = 8'h13;
  localparam logic [7:0] ADDR_CHAN2_HIGH = 8'h14;
  localparam logic [7:0] ADDR_CHAN3_LOW  = 8'h15;
  localparam logic [7:0] ADDR_CHAN3_HIGH = 8'h16;
  localparam logic [7:0] RESET_BYTE      = 8'h00;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;
  localparam int         NUM_BYTES       = 4;
  localparam int         IDX_W           = 2;
  localparam logic [7:0] REV_COMPRESSED_MAX = 8'h01;   // revisions at or below use compressed form

  // host register access, one byte per strobe
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pth_reg_req_type;

  // one measurement result from the sequencer
  typedef struct packed {
    logic        valid;
    logic        chan3;
    logic [15:0] value;
  } pth_meas_type;
endpackage

/* src/pth_threshold_regs.sv */
// file: proximity channel 2/3 threshold registers and autonomous compare
`timescale 1ns/100ps
// Summary of operation
// - channel 2 threshold 16 bits at 0x13/0x14
// - compare channel 2 results, flag interrupt
// - channel 3 threshold, low byte at 0x15
// - compare channel 3 results, flag interrupt
// - bytes take effect singly, not atomic
// - bytes read/write, reset to zero
// - early revisions: 8-bit compressed channel 2 threshold
module pth_threshold_regs #(
  parameter logic [7:0] SILICON_REV = 8'h05   // arbitrary revision code
) (
  input  wire logic                     clk,         // 100 MHz system clock
  input  wire logic                     reset_n,     // async reset, active low
  input  wire pth_pkg::pth_reg_req_type reg_req,     // host byte access
  input  wire pth_pkg::pth_meas_type    meas,        // measurement result
  output logic      [7:0]               reg_rdata,   // read byte
  output logic                          reg_rvalid,  // read data valid pulse
  output logic                          chan2_above, // channel 2 over threshold pulse
  output logic                          chan3_above, // channel 3 over threshold pulse
  output logic      [15:0]              chan2_thresh,// effective channel 2 threshold
  output logic      [15:0]              chan3_thresh // effective channel 3 threshold
);
  // byte index from register address
  function automatic logic [pth_pkg::IDX_W-1:0] addr_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - pth_pkg::ADDR_CHAN2_LOW;
    return d[pth_pkg::IDX_W-1:0];
  endfunction

  // compressed 8-bit to 16-bit: upper nibble exponent, lower mantissa
  function automatic logic [15:0] expand(input logic [7:0] c);
    logic [19:0] m;
    m = {16'h0000, c[3:0]} << c[7:4];
    return m[15:0];
  endfunction

  logic [31:0]               bytes_w;
  logic [7:0]                rd_byte_w;
  logic [7:0]                rd_sel_w;
  logic                      hit_w;
  logic                      wr_hit_w;
  logic [pth_pkg::IDX_W-1:0] idx_w;
  logic                      rd_hit_r;
  logic                      rd_pend_r;
  logic [15:0]               th2_w;
  logic [15:0]               th3_w;
  logic                      compressed_w;

  // address decode for the mapped bytes; one index serves write and read
  assign hit_w = (reg_req.addr >= pth_pkg::ADDR_CHAN2_LOW) && (reg_req.addr <= pth_pkg::ADDR_CHAN3_HIGH);
  assign idx_w = addr_idx(reg_req.addr);
  assign wr_hit_w = reg_req.wr_en & hit_w;
  assign compressed_w = (SILICON_REV <= pth_pkg::REV_COMPRESSED_MAX);

  // storage; each byte write takes effect alone
  pth_byte_mem u_mem (
    .clk       (clk),
    .reset_n   (reset_n),
    .wr_en     (wr_hit_w),
    .wr_idx    (idx_w),
    .wr_data   (reg_req.wdata),
    .rd_idx    (idx_w),
    .rd_data   (rd_byte_w),
    .all_bytes (bytes_w)
  );

  // assemble thresholds, compressed form on early silicon
  assign th2_w = compressed_w ? expand(bytes_w[7:0]) : bytes_w[15:0];
  assign th3_w = bytes_w[31:16];

  // read pipeline: memory output one cycle after request, no side effects
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_pend_r <= 1'b0;
      rd_hit_r  <= 1'b0;
    end else begin
      rd_pend_r <= reg_req.rd_en;
      rd_hit_r  <= hit_w;
    end
  end

  // stored byte, or zero for an unmapped address
  assign rd_sel_w = rd_hit_r ? rd_byte_w : pth_pkg::READ_UNMAPPED;

  // registered read answer, two cycles after request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata  <= pth_pkg::RESET_BYTE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_pend_r;
      if (rd_pend_r) reg_rdata <= rd_sel_w;
    end
  end

  // autonomous compares against current bytes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chan2_above  <= 1'b0;
      chan3_above  <= 1'b0;
      chan2_thresh <= 16'h0000;
      chan3_thresh <= 16'h0000;
    end else begin
      chan2_above  <= meas.valid & ~meas.chan3 & (meas.value > th2_w);
      chan3_above  <= meas.valid & meas.chan3 & (meas.value > th3_w);
      chan2_thresh <= th2_w;
      chan3_thresh <= th3_w;
    end
  end

  // assertions on the compare, write and read paths
  property p_chan2_cmp;
    @(posedge clk) disable iff (!reset_n)
      (meas.valid && !meas.chan3 && meas.value > th2_w) |=> chan2_above;
  endproperty
  a_chan2_cmp: assert property (p_chan2_cmp) else $error("channel 2 compare missed");

  property p_chan3_cmp;
    @(posedge clk) disable iff (!reset_n)
      (meas.valid && meas.chan3 && meas.value > th3_w) |=> chan3_above;
  endproperty
  a_chan3_cmp: assert property (p_chan3_cmp) else $error("channel 3 compare missed");

  property p_no_false;
    @(posedge clk) disable iff (!reset_n)
      !meas.valid |=> !chan2_above && !chan3_above;
  endproperty
  a_no_false: assert property (p_no_false) else $error("compare flag without result");

  property p_low_write;
    @(posedge clk) disable iff (!reset_n)
      (reg_req.wr_en && reg_req.addr == pth_pkg::ADDR_CHAN3_LOW) |=> ##1 chan3_thresh[7:0] == $past(reg_req.wdata, 2);
  endproperty
  a_low_write: assert property (p_low_write) else $error("channel 3 low byte not applied");

  property p_single_byte;
    @(posedge clk) disable iff (!reset_n || compressed_w)
      (reg_req.wr_en && reg_req.addr == pth_pkg::ADDR_CHAN2_LOW) |=> ##1 chan2_thresh[15:8] == $past(chan2_thresh[15:8]);
  endproperty
  a_single_byte: assert property (p_single_byte) else $error("high byte changed by low write");

  property p_high_write;
    @(posedge clk) disable iff (!reset_n || compressed_w)
      (reg_req.wr_en && reg_req.addr == pth_pkg::ADDR_CHAN2_HIGH) |=> ##1 chan2_thresh[15:8] == $past(reg_req.wdata, 2);
  endproperty
  a_high_write: assert property (p_high_write) else $error("channel 2 high byte not applied");

  property p_readback;
    @(posedge clk) disable iff (!reset_n)
      (reg_req.wr_en && reg_req.addr == pth_pkg::ADDR_CHAN2_LOW) ##1
      (reg_req.rd_en && reg_req.addr == pth_pkg::ADDR_CHAN2_LOW && !reg_req.wr_en)
      |-> ##2 reg_rvalid && reg_rdata == $past(reg_req.wdata, 3);
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  property p_rvalid_timing;
    @(posedge clk) disable iff (!reset_n)
      reg_req.rd_en |-> ##2 reg_rvalid;
  endproperty
  a_rvalid_timing: assert property (p_rvalid_timing) else $error("read answer late");

  property p_compressed;
    @(posedge clk) disable iff (!reset_n || !compressed_w)
      1'b1 |=> chan2_thresh == expand($past(bytes_w[7:0]));
  endproperty
  a_compressed: assert property (p_compressed) else $error("compressed threshold wrong");

  // a result at or below its threshold raises nothing
  property p_chan2_strict;
    @(posedge clk) disable iff (!reset_n)
      (meas.valid && !meas.chan3 && meas.value <= th2_w) |=> !chan2_above;
  endproperty
  a_chan2_strict: assert property (p_chan2_strict) else $error("channel 2 flag at or below threshold");

  property p_chan3_strict;
    @(posedge clk) disable iff (!reset_n)
      (meas.valid && meas.chan3 && meas.value <= th3_w) |=> !chan3_above;
  endproperty
  a_chan3_strict: assert property (p_chan3_strict) else $error("channel 3 flag at or below threshold");

  // each result raises only the flag of its own channel
  property p_chan2_route;
    @(posedge clk) disable iff (!reset_n)
      (meas.valid && meas.chan3) |=> !chan2_above;
  endproperty
  a_chan2_route: assert property (p_chan2_route) else $error("channel 2 flag from channel 3 result");

  property p_chan3_route;
    @(posedge clk) disable iff (!reset_n)
      (meas.valid && !meas.chan3) |=> !chan3_above;
  endproperty
  a_chan3_route: assert property (p_chan3_route) else $error("channel 3 flag from channel 2 result");

  // channel 2 low byte lands on full-width silicon
  property p_low2_write;
    @(posedge clk) disable iff (!reset_n || compressed_w)
      (reg_req.wr_en && reg_req.addr == pth_pkg::ADDR_CHAN2_LOW) |=> ##1 chan2_thresh[7:0] == $past(reg_req.wdata, 2);
  endproperty
  a_low2_write: assert property (p_low2_write) else $error("channel 2 low byte not applied");

  // a read answer comes only for a read, unmapped bytes read zero
  property p_rvalid_only;
    @(posedge clk) disable iff (!reset_n)
      !reg_req.rd_en |-> ##2 !reg_rvalid;
  endproperty
  a_rvalid_only: assert property (p_rvalid_only) else $error("read answer without request");

  property p_unmapped;
    @(posedge clk) disable iff (!reset_n)
      (reg_req.rd_en && !hit_w) |-> ##2 reg_rdata == pth_pkg::READ_UNMAPPED;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // a read leaves both thresholds untouched
  property p_read_quiet;
    @(posedge clk) disable iff (!reset_n)
      (reg_req.rd_en && !reg_req.wr_en) |=> ##1 $stable(chan2_thresh) && $stable(chan3_thresh);
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read disturbed a threshold");

  c_chan2_hit: cover property (@(posedge clk) disable iff (!reset_n) chan2_above);
  c_chan3_hit: cover property (@(posedge clk) disable iff (!reset_n) chan3_above);
  c_read: cover property (@(posedge clk) disable iff (!reset_n) reg_rvalid && reg_rdata != 8'h00);
  c_back_to_back: cover property (@(posedge clk) disable iff (!reset_n) reg_req.wr_en ##1 reg_req.rd_en);
  c_compressed: cover property (@(posedge clk) disable iff (!reset_n) compressed_w && chan2_above);
endmodule

/* tb/pth_host_model.sv */
// host model: byte register access and measurement source
`timescale 1ns/100ps
module pth_host_model (
  input  wire logic                     clk,         // system clock
  input  wire logic [7:0]               reg_rdata,   // read byte
  input  wire logic                     reg_rvalid,  // read answer pulse
  input  wire logic                     chan2_above, // channel 2 flag
  input  wire logic                     chan3_above, // channel 3 flag
  output pth_pkg::pth_reg_req_type      reg_req,     // byte access
  output pth_pkg::pth_meas_type         meas         // result
);
  // idle at time zero
  initial begin
    reg_req = '0;
    meas    = '0;
  end
  // one-cycle write strobe, released fields inverted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_req = '{1'b1, 1'b0, a, d};
    @(posedge clk) #1;
    reg_req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  // one-cycle read strobe, answer awaited under a bound
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1;
    reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) #1;
    reg_req = '{1'b0, 1'b0, ~a, 8'hff};
    d = 8'hxx;
    repeat (3) begin
      if (reg_rvalid === 1'b1) d = reg_rdata;
      @(posedge clk) #1;
    end
  endtask
  // write a byte, then read the same byte at the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d);
    @(posedge clk) #1;
    reg_req = '{1'b1, 1'b0, a, wd};
    @(posedge clk) #1;
    reg_req = '{1'b0, 1'b1, a, ~wd};
    @(posedge clk) #1;
    reg_req = '{1'b0, 1'b0, ~a, wd};
    d = 8'hxx;
    repeat (3) begin
      if (reg_rvalid === 1'b1) d = reg_rdata;
      @(posedge clk) #1;
    end
  endtask
  // one-cycle result strobe, flags sampled the cycle after
  task automatic measure(input logic c3, input logic [15:0] v, output logic a2, output logic a3);
    @(posedge clk) #1;
    meas = '{1'b1, c3, v};
    @(posedge clk) #1;
    meas = '{1'b0, ~c3, ~v};
    a2 = chan2_above;
    a3 = chan3_above;
  endtask
endmodule

/* tb/pth_threshold_regs_bench.sv */
// self-checking bench for the proximity threshold bank
`timescale 1ns/100ps
module pth_threshold_regs_bench;
  logic                     clk     = 1'b0;
  logic                     reset_n = 1'b0;
  pth_pkg::pth_reg_req_type reg_req;
  pth_pkg::pth_meas_type    meas;
  logic [7:0]               reg_rdata, d;
  logic                     reg_rvalid, chan2_above, chan3_above, a2, a3;
  logic [15:0]              chan2_thresh, chan3_thresh;
  logic                     early_above2;
  logic [15:0]              early_thresh2;
  int                       n_errors = 0;
  int                       checks   = 0;
  // clock, 10 ns period
  always #5 clk = ~clk;
  pth_threshold_regs i_dut (.clk(clk), .reset_n(reset_n), .reg_req(reg_req), .meas(meas),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .chan2_above(chan2_above),
    .chan3_above(chan3_above), .chan2_thresh(chan2_thresh), .chan3_thresh(chan3_thresh));
  pth_host_model i_host (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .chan2_above(chan2_above), .chan3_above(chan3_above), .reg_req(reg_req), .meas(meas));
  // early-revision copy on the same host, compressed channel 2 threshold
  pth_threshold_regs #(.SILICON_REV(pth_pkg::REV_COMPRESSED_MAX)) i_dut_early (.clk(clk), .reset_n(reset_n),
    .reg_req(reg_req), .meas(meas), .reg_rdata(), .reg_rvalid(), .chan2_above(early_above2), .chan3_above(),
    .chan2_thresh(early_thresh2), .chan3_thresh());
  // read byte compare
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // compare flag pair compare
  task automatic chk_flag(input logic [1:0] got, input logic [1:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  // threshold word compare
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // bytes read zero after reset
  task automatic t_reset;
    i_host.rd(8'h13, d);
    chk_byte(d, pth_pkg::RESET_BYTE, "low2");
    i_host.rd(8'h14, d);
    chk_byte(d, pth_pkg::RESET_BYTE, "high2");
    i_host.rd(8'h15, d);
    chk_byte(d, pth_pkg::RESET_BYTE, "low3");
    chk_word(chan2_thresh, 16'h0000, "th2");
    $display("test reset done");
  endtask
  // writes with an idle cycle between, read back, unmapped address
  task automatic t_rw;
    i_host.wr(8'h13, 8'ha5);
    i_host.wr(8'h14, 8'h3c);
    i_host.wr(8'h15, 8'h7e);
    i_host.wr(8'h20, 8'h55);
    i_host.rd(8'h13, d);
    chk_byte(d, 8'ha5, "low2");
    i_host.rd(8'h14, d);
    chk_byte(d, 8'h3c, "high2");
    i_host.rd(8'h15, d);
    chk_byte(d, 8'h7e, "low3");
    i_host.rd(8'h20, d);
    chk_byte(d, pth_pkg::READ_UNMAPPED, "unmapped");
    chk_word(chan2_thresh, 16'h3ca5, "th2");
    chk_word(chan3_thresh, 16'h007e, "th3");
    chk_word(early_thresh2, 16'h1400, "th2 compressed");
    $display("test readback done");
  endtask
  // strict compare at the threshold boundary
  task automatic t_cmp;
    i_host.measure(1'b0, 16'h3ca6, a2, a3);
    chk_flag({a2, a3}, 2'b10, "c2 over");
    i_host.measure(1'b0, 16'h3ca5, a2, a3);
    chk_flag({a2, a3}, 2'b00, "c2 eq");
    chk_flag({early_above2, a3}, 2'b10, "c2 eq, compressed over");
    i_host.measure(1'b1, 16'h007f, a2, a3);
    chk_flag({a2, a3}, 2'b01, "c3 over");
    i_host.measure(1'b1, 16'h007e, a2, a3);
    chk_flag({a2, a3}, 2'b00, "c3 eq");
    $display("test compare done");
  endtask
  // one byte rewritten alone takes effect at once, read back the next cycle
  task automatic t_mixed;
    i_host.wr_rd(8'h13, 8'h00, d);
    chk_byte(d, 8'h00, "next-cycle read");
    chk_word(chan2_thresh, 16'h3c00, "mixed");
    i_host.measure(1'b0, 16'h3c01, a2, a3);
    chk_flag({a2, a3}, 2'b10, "mixed cmp");
    $display("test mixed done");
  endtask
  // reset in mid-run returns written bytes to zero
  task automatic t_rereset;
    @(posedge clk) #1;
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    i_host.rd(8'h14, d);
    chk_byte(d, pth_pkg::RESET_BYTE, "high2 after reset");
    chk_word(chan2_thresh, 16'h0000, "th2 after reset");
    $display("test mid-run reset done");
  endtask
  // reset, then the tests
  initial begin
    repeat (20) @(posedge clk);
    #1 reset_n = 1'b1;
    t_reset;
    t_rw;
    t_cmp;
    t_mixed;
    t_rereset;
    wrap_up;
  end
  // watchdog
  initial begin
    #20000;
    n_errors++;
    wrap_up;
  end
endmodule
